// ===== design/bcx_cfg.svh
// Offsets, field positions, reset values and cycle counts of the branch unit
`ifndef BCX_CFG_SVH
`define BCX_CFG_SVH

`define BCX_AW            12
`define BCX_ADDR_CTRL     12'h000
`define BCX_ADDR_STAT     12'h004
`define BCX_ADDR_PSW      12'h008
`define BCX_ADDR_PC       12'h00C
`define BCX_ADDR_CYC      12'h010

`define BCX_CTRL_RST      3'h0
`define BCX_CLK_SEL_MAX   3'h4
`define BCX_PSW_RST       8'h00
`define BCX_PC_RST        16'h0000

`define BCX_PSW_IE        7
`define BCX_PSW_Z         6
`define BCX_PSW_RBS1      5
`define BCX_PSW_AC        4
`define BCX_PSW_RBS0      3
`define BCX_PSW_CY        0

`define BCX_STAT_BUSY     0
`define BCX_STAT_TAKEN    1
`define BCX_STAT_HALT     2
`define BCX_STAT_STOP     3

`define BCX_CYC_NOP       10'd4
`define BCX_CYC_SEL       10'd8
`define BCX_CYC_12        10'd12
`define BCX_CYC_16        10'd16
`define BCX_CYC_18        10'd18
`define BCX_CYC_20        10'd20
`define BCX_CYC_22        10'd22
`define BCX_CYC_24        10'd24
`define BCX_CYC_PER_WAIT  10'd2

`define BCX_LEN_1         16'h0001
`define BCX_LEN_2         16'h0002
`define BCX_LEN_3         16'h0003
`define BCX_LEN_4         16'h0004

`endif

// ===== design/bcx_exec.sv
// Branch and CPU-control execution unit with an APB register slave
// Function
// - Unconditional jump: absolute, relative, accumulator-X
// - Carry and zero conditional jumps, PC+2
// - Bit-set jump short-direct and accumulator forms
// - Bit-set jump on special register, PC+4
// - Bit-set jump on status word, PC+3
// - Bit-clear jump branches when bit is zero
// - Test-clear jump clears the tested set bit
// - Decrement then branch on non-zero result
// - Interrupts-on sets interrupt master enable
// - Interrupts-off clears interrupt master enable
// - Indirect bit tests add two per read wait
// - Indirect test-clear adds two per write wait
// - Counted clocks are core clock periods
// - Fast RAM or no data uses short count
// - Fetch outside internal ROM adds cycles
`timescale 1ns/1ps
`include "bcx_cfg.svh"

module bcx_exec #(
	parameter int CW = 10,
	parameter int WW = 4
) (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [`BCX_AW-1:0]   paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire logic                 issue_valid,
	output logic                      issue_ready,
	input  wire bcx_pkg::bcx_op_t     issue_op,
	input  wire bcx_pkg::bcx_mode_t   issue_mode,
	input  wire logic [15:0]          issue_addr16,
	input  wire logic [7:0]           issue_offset,
	input  wire logic [2:0]           issue_bit,
	input  wire logic [1:0]           issue_bank,
	input  wire logic                 issue_fast_area,
	input  wire logic [7:0]           issue_fetch_extra,
	input  wire logic [WW-1:0]        issue_rd_waits,
	input  wire logic [WW-1:0]        issue_wr_waits,
	input  wire logic [7:0]           opnd_data,
	input  wire logic [7:0]           acc_data,
	input  wire logic [7:0]           x_data,
	input  wire logic [7:0]           b_data,
	input  wire logic [7:0]           c_data,
	input  wire logic                 wake,
	output logic                      done,
	output logic                      taken,
	output logic      [15:0]          pc,
	output logic                      wb_valid,
	output bcx_pkg::bcx_mode_t        wb_sel,
	output logic      [7:0]           wb_data,
	output logic      [7:0]           program_status_word,
	output logic                      int_master_enable,
	output logic      [1:0]           bank_choice_bits,
	output logic                      halt_mode,
	output logic                      stop_mode
);

	bcx_pkg::bcx_state_t state_ff;
	bcx_pkg::bcx_op_t    op_ff;
	bcx_pkg::bcx_mode_t  mode_ff, wb_sel_ff;
	logic [15:0]         addr_ff, pc_ff;
	logic [7:0]          offset_ff, opnd_ff, acc_ff, x_ff, b_ff, c_ff;
	logic [7:0]          psw_ff, wb_data_ff;
	logic [2:0]          bit_ff, clk_sel_ff;
	logic [1:0]          bank_ff;
	logic [CW-1:0]       cnt_ff, last_cyc_ff;
	logic [3:0]          div_ff;
	logic                done_ff, taken_ff, wb_valid_ff, halt_ff, stop_ff;
	logic [31:0]         prdata_ff;
	logic                core_tick, start, finish, branch, bit_val;
	logic                apb_setup, apb_wr, mapped;
	logic [3:0]          div_mask;
	logic [CW-1:0]       nxt_total;
	logic [7:0]          src_byte, dec_val;
	logic [15:0]         pc_next, pc_rel, nxt_pc;

	// Base clocks for one instruction; slow area picks the long column
	function automatic logic [CW-1:0] base_cycles(
		input bcx_pkg::bcx_op_t   op,
		input bcx_pkg::bcx_mode_t md,
		input logic               fast
	);
		logic [9:0] c;
		case (op)
			bcx_pkg::OP_JUMP_ALWAYS:
				c = (md == bcx_pkg::MD_AX) ? `BCX_CYC_16 : `BCX_CYC_12;
			bcx_pkg::OP_BIT_SET:
				case (md)
					bcx_pkg::MD_SHORT: c = fast ? `BCX_CYC_16 : `BCX_CYC_18;
					bcx_pkg::MD_SFR:   c = `BCX_CYC_22;
					bcx_pkg::MD_PSW:   c = `BCX_CYC_18;
					bcx_pkg::MD_IND:   c = fast ? `BCX_CYC_20 : `BCX_CYC_22;
					default:           c = `BCX_CYC_16;
				endcase
			bcx_pkg::OP_BIT_CLEAR:
				case (md)
					bcx_pkg::MD_ACC: c = `BCX_CYC_16;
					bcx_pkg::MD_IND, bcx_pkg::MD_SHORT: c = fast ? `BCX_CYC_20 : `BCX_CYC_22;
					default:         c = `BCX_CYC_22;
				endcase
			bcx_pkg::OP_TEST_CLEAR:
				case (md)
					bcx_pkg::MD_ACC: c = `BCX_CYC_16;
					bcx_pkg::MD_IND, bcx_pkg::MD_SHORT: c = fast ? `BCX_CYC_20 : `BCX_CYC_24;
					default:         c = `BCX_CYC_24;
				endcase
			bcx_pkg::OP_DEC_JNZ:
				c = (md != bcx_pkg::MD_SHORT) ? `BCX_CYC_12 :
					fast ? `BCX_CYC_16 : `BCX_CYC_20;
			bcx_pkg::OP_BANK_CHOOSE:  c = `BCX_CYC_SEL;
			bcx_pkg::OP_NO_OPERATION: c = `BCX_CYC_NOP;
			default:                  c = `BCX_CYC_12;
		endcase
		base_cycles = CW'(c);
	endfunction : base_cycles

	// Instruction length in bytes, which sets the relative base
	function automatic logic [15:0] instr_len(
		input bcx_pkg::bcx_op_t   op,
		input bcx_pkg::bcx_mode_t md
	);
		case (op)
			bcx_pkg::OP_JUMP_ALWAYS:
				instr_len = (md == bcx_pkg::MD_ABS) ? `BCX_LEN_3 : `BCX_LEN_2;
			bcx_pkg::OP_BIT_SET:
				instr_len = (md == bcx_pkg::MD_SFR) ? `BCX_LEN_4 : `BCX_LEN_3;
			bcx_pkg::OP_BIT_CLEAR, bcx_pkg::OP_TEST_CLEAR:
				instr_len = (md == bcx_pkg::MD_ACC || md == bcx_pkg::MD_IND) ?
					`BCX_LEN_3 : `BCX_LEN_4;
			bcx_pkg::OP_DEC_JNZ:
				instr_len = (md == bcx_pkg::MD_SHORT) ? `BCX_LEN_3 : `BCX_LEN_2;
			bcx_pkg::OP_NO_OPERATION: instr_len = `BCX_LEN_1;
			default:                  instr_len = `BCX_LEN_2;
		endcase
	endfunction : instr_len

	// Core clock is pclk divided by a power of two chosen by software
	assign div_mask  = 4'(({1'b0, 4'h1} << clk_sel_ff) - 5'h01);
	assign core_tick = (div_ff == div_mask);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_ff <= 4'h0;
		end else if (core_tick) begin
			div_ff <= 4'h0;
		end else begin
			div_ff <= div_ff + 4'h1;
		end
	end

	assign issue_ready = (state_ff == bcx_pkg::ST_IDLE) && !halt_ff && !stop_ff;
	assign start       = issue_valid && issue_ready;
	assign finish      = (state_ff == bcx_pkg::ST_RUN) && core_tick &&
	                     (cnt_ff == CW'(1));

	// Wait states only count when the operand lies outside fast RAM
	always_comb begin
		nxt_total = base_cycles(issue_op, issue_mode, issue_fast_area) +
			CW'(issue_fetch_extra);
		if (issue_mode == bcx_pkg::MD_IND && !issue_fast_area &&
		    issue_op inside {bcx_pkg::OP_BIT_SET, bcx_pkg::OP_BIT_CLEAR,
		                     bcx_pkg::OP_TEST_CLEAR}) begin
			nxt_total = nxt_total +
				CW'(`BCX_CYC_PER_WAIT * issue_rd_waits);
			if (issue_op == bcx_pkg::OP_TEST_CLEAR)
				nxt_total = nxt_total +
					CW'(`BCX_CYC_PER_WAIT * issue_wr_waits);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff    <= bcx_pkg::ST_IDLE;
			{cnt_ff, last_cyc_ff} <= '0;
		end else begin
			case (state_ff)
				bcx_pkg::ST_IDLE: begin
					if (start) begin
						state_ff    <= bcx_pkg::ST_RUN;
						cnt_ff      <= nxt_total;
						last_cyc_ff <= nxt_total;
					end
				end
				bcx_pkg::ST_RUN: begin
					if (finish)
						state_ff <= bcx_pkg::ST_IDLE;
					if (core_tick)
						cnt_ff <= cnt_ff - CW'(1);
				end
				default: state_ff <= bcx_pkg::ST_IDLE;
			endcase
		end
	end
	// Operands are captured at issue so the source may move on
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_ff   <= bcx_pkg::OP_NO_OPERATION;
			mode_ff <= bcx_pkg::MD_NONE;
			{addr_ff, offset_ff, bit_ff, bank_ff} <= '0;
			{opnd_ff, acc_ff, x_ff, b_ff, c_ff}   <= '0;
		end else if (start) begin
			op_ff   <= issue_op;
			mode_ff <= issue_mode;
			{addr_ff, offset_ff, bit_ff, bank_ff} <=
				{issue_addr16, issue_offset, issue_bit, issue_bank};
			{opnd_ff, acc_ff, x_ff, b_ff, c_ff} <=
				{opnd_data, acc_data, x_data, b_data, c_data};
		end
	end

	// Branch decision and target
	always_comb begin
		case (mode_ff)
			bcx_pkg::MD_ACC:  src_byte = acc_ff;
			bcx_pkg::MD_PSW:  src_byte = psw_ff;
			bcx_pkg::MD_REGB: src_byte = b_ff;
			bcx_pkg::MD_REGC: src_byte = c_ff;
			default:          src_byte = opnd_ff;
		endcase
		bit_val = src_byte[bit_ff];
		dec_val = src_byte - 8'h01;
		case (op_ff)
			bcx_pkg::OP_JUMP_ALWAYS:   branch = 1'b1;
			bcx_pkg::OP_JUMP_IF_CARRY: branch = psw_ff[`BCX_PSW_CY];
			bcx_pkg::OP_JUMP_IF_NO_CY: branch = !psw_ff[`BCX_PSW_CY];
			bcx_pkg::OP_JUMP_IF_ZERO:  branch = psw_ff[`BCX_PSW_Z];
			bcx_pkg::OP_JUMP_IF_NZ:    branch = !psw_ff[`BCX_PSW_Z];
			bcx_pkg::OP_BIT_SET:       branch = bit_val;
			bcx_pkg::OP_BIT_CLEAR:     branch = !bit_val;
			bcx_pkg::OP_TEST_CLEAR:    branch = bit_val;
			bcx_pkg::OP_DEC_JNZ:       branch = (dec_val != 8'h00);
			default:                   branch = 1'b0;
		endcase
		pc_next = pc_ff + instr_len(op_ff, mode_ff);
		pc_rel  = pc_next + {{8{offset_ff[7]}}, offset_ff};
		nxt_pc  = pc_next;
		if (branch) begin
			if (op_ff == bcx_pkg::OP_JUMP_ALWAYS &&
			    mode_ff == bcx_pkg::MD_ABS)
				nxt_pc = addr_ff;
			else if (op_ff == bcx_pkg::OP_JUMP_ALWAYS &&
			         mode_ff == bcx_pkg::MD_AX)
				nxt_pc = {acc_ff, x_ff};
			else
				nxt_pc = pc_rel;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_ff    <= `BCX_PC_RST;
			{done_ff, taken_ff} <= 2'h0;
		end else begin
			done_ff <= finish;
			if (finish) begin
				pc_ff    <= nxt_pc;
				taken_ff <= branch;
			end
		end
	end

	// Operand write-back: decremented value or cleared bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{wb_valid_ff, wb_data_ff} <= 9'h000;
			wb_sel_ff   <= bcx_pkg::MD_NONE;
		end else begin
			wb_valid_ff <= 1'b0;
			if (finish && op_ff == bcx_pkg::OP_DEC_JNZ) begin
				wb_valid_ff <= 1'b1;
				wb_data_ff  <= dec_val;
				wb_sel_ff   <= mode_ff;
			end else if (finish && op_ff == bcx_pkg::OP_TEST_CLEAR &&
			             bit_val && mode_ff != bcx_pkg::MD_PSW) begin
				wb_valid_ff <= 1'b1;
				wb_data_ff  <= src_byte & ~(8'h01 << bit_ff);
				wb_sel_ff   <= mode_ff;
			end
		end
	end

	// Status word: enable, bank choice and flag clears
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			psw_ff <= `BCX_PSW_RST;
		end else if (finish) begin
			case (op_ff)
				bcx_pkg::OP_INTS_ON:  psw_ff[`BCX_PSW_IE] <= 1'b1;
				bcx_pkg::OP_INTS_OFF: psw_ff[`BCX_PSW_IE] <= 1'b0;
				bcx_pkg::OP_BANK_CHOOSE:
					{psw_ff[`BCX_PSW_RBS1], psw_ff[`BCX_PSW_RBS0]} <= bank_ff;
				bcx_pkg::OP_TEST_CLEAR: begin
					if (mode_ff == bcx_pkg::MD_PSW && bit_val)
						psw_ff[bit_ff] <= 1'b0;
				end
				default: psw_ff <= psw_ff;
			endcase
		end
	end

	// Low-power modes hold issue off until woken
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{halt_ff, stop_ff} <= 2'h0;
		end else begin
			// Entry wins over a wake in the same cycle
			halt_ff <= (finish && op_ff == bcx_pkg::OP_HALT) ||
			           (halt_ff && !wake);
			stop_ff <= (finish && op_ff == bcx_pkg::OP_STOP) ||
			           (stop_ff && !wake);
		end
	end

	// APB slave: zero wait states, read data prepared in setup
	assign apb_setup = psel && !penable;
	assign apb_wr    = psel && penable && pwrite;
	assign mapped    = paddr inside {`BCX_ADDR_CTRL, `BCX_ADDR_STAT,
	                   `BCX_ADDR_PSW, `BCX_ADDR_PC, `BCX_ADDR_CYC};
	assign pready    = 1'b1;
	assign pslverr   = psel && penable && !mapped;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_sel_ff <= `BCX_CTRL_RST;
		end else if (apb_wr && paddr == `BCX_ADDR_CTRL) begin
			// Out of range selects clamp to the slowest divider
			if (pwdata[2:0] > `BCX_CLK_SEL_MAX)
				clk_sel_ff <= `BCX_CLK_SEL_MAX;
			else
				clk_sel_ff <= pwdata[2:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h0000_0000;
		end else if (apb_setup && !pwrite) begin
			case (paddr)
				`BCX_ADDR_CTRL: prdata_ff <= {29'h0, clk_sel_ff};
				`BCX_ADDR_STAT: prdata_ff <= {28'h0, stop_ff, halt_ff, taken_ff,
				                              state_ff == bcx_pkg::ST_RUN};
				`BCX_ADDR_PSW:  prdata_ff <= {24'h0, psw_ff};
				`BCX_ADDR_PC:   prdata_ff <= {16'h0, pc_ff};
				`BCX_ADDR_CYC:  prdata_ff <= 32'(last_cyc_ff);
				default:        prdata_ff <= 32'h0000_0000;
			endcase
		end
	end

	assign prdata            = prdata_ff;
	assign done              = done_ff;
	assign taken             = taken_ff;
	assign pc                = pc_ff;
	assign wb_valid          = wb_valid_ff;
	assign wb_sel            = wb_sel_ff;
	assign wb_data           = wb_data_ff;
	assign program_status_word               = psw_ff;
	assign int_master_enable = psw_ff[`BCX_PSW_IE];
	assign bank_choice_bits  = {psw_ff[`BCX_PSW_RBS1], psw_ff[`BCX_PSW_RBS0]};
	assign halt_mode         = halt_ff;
	assign stop_mode         = stop_ff;

endmodule : bcx_exec

// ===== design/bcx_pkg.sv
// Types of the branch and CPU-control execution unit
package bcx_pkg;

	typedef enum logic [3:0] {
		OP_JUMP_ALWAYS   = 4'h0,
		OP_JUMP_IF_CARRY = 4'h1,
		OP_JUMP_IF_NO_CY = 4'h2,
		OP_JUMP_IF_ZERO  = 4'h3,
		OP_JUMP_IF_NZ    = 4'h4,
		OP_BIT_SET       = 4'h5,
		OP_BIT_CLEAR     = 4'h6,
		OP_TEST_CLEAR    = 4'h7,
		OP_DEC_JNZ       = 4'h8,
		OP_BANK_CHOOSE   = 4'h9,
		OP_NO_OPERATION  = 4'hA,
		OP_INTS_ON       = 4'hB,
		OP_INTS_OFF      = 4'hC,
		OP_HALT          = 4'hD,
		OP_STOP          = 4'hE
	} bcx_op_t;

	typedef enum logic [3:0] {
		MD_ABS   = 4'h0,
		MD_REL   = 4'h1,
		MD_AX    = 4'h2,
		MD_SHORT = 4'h3,
		MD_SFR   = 4'h4,
		MD_ACC   = 4'h5,
		MD_PSW   = 4'h6,
		MD_IND   = 4'h7,
		MD_REGB  = 4'h8,
		MD_REGC  = 4'h9,
		MD_NONE  = 4'hF
	} bcx_mode_t;

	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_RUN  = 1'b1
	} bcx_state_t;

endpackage : bcx_pkg

// ===== verification/bcx_exec_chk.sv
// Port checker of the branch and CPU-control unit
`timescale 1ns/1ps
`include "bcx_cfg.svh"
module bcx_exec_chk (
	input wire logic               pclk,
	input wire logic               presetn,
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pwrite,
	input wire logic [11:0]        paddr,
	input wire logic [31:0]        pwdata,
	input wire logic               pslverr,
	input wire logic               issue_valid,
	input wire logic               issue_ready,
	input wire bcx_pkg::bcx_op_t   issue_op,
	input wire bcx_pkg::bcx_mode_t issue_mode,
	input wire logic [15:0]        issue_addr16,
	input wire logic [7:0]         issue_fetch_extra,
	input wire logic               done,
	input wire logic               wb_valid,
	input wire logic [15:0]        pc,
	input wire logic [7:0]         program_status_word,
	input wire logic               int_master_enable,
	input wire logic [1:0]         bank_choice_bits,
	input wire logic               halt_mode,
	input wire logic               stop_mode
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic sel0_ff;
	logic go;
	logic go0;
	logic mapped;
	assign go = issue_valid && issue_ready;
	// Exact latencies hold only with an undivided core clock and no extra
	assign go0 = go && sel0_ff && issue_fetch_extra == 8'h00;
	assign mapped = paddr inside {12'h000, 12'h004, 12'h008, 12'h00C, 12'h010};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			sel0_ff <= 1'b1;
		else if (psel && penable && pwrite && paddr == `BCX_ADDR_CTRL)
			sel0_ff <= pwdata[2:0] == 3'h0;
	end
	sequence s_nop_go;
		go0 && issue_op == bcx_pkg::OP_NO_OPERATION;
	endsequence
	sequence s_quiet4;
		!done [*4];
	endsequence
	AST_NOP_TIME: assert property (s_nop_go |=> s_quiet4 ##1 done)
		else $error("nop time");
	AST_NOP_PC: assert property (s_nop_go |->
		##5 (pc == $past(pc, 5) + 16'h0001))
		else $error("nop pc");
	AST_JMP_ABS: assert property (go0 &&
		issue_op == bcx_pkg::OP_JUMP_ALWAYS && issue_mode == bcx_pkg::MD_ABS
		|-> ##13 (done && pc == $past(issue_addr16, 13)))
		else $error("jump abs");
	AST_IE_ON: assert property (go0 && issue_op == bcx_pkg::OP_INTS_ON
		|-> ##13 (done && int_master_enable))
		else $error("ints on");
	AST_IE_OFF: assert property (go0 && issue_op == bcx_pkg::OP_INTS_OFF
		|-> ##13 (done && !int_master_enable))
		else $error("ints off");
	AST_IME_BIT: assert property (int_master_enable == program_status_word[7])
		else $error("enable bit");
	AST_BANK: assert property (bank_choice_bits == {program_status_word[5], program_status_word[3]})
		else $error("bank bits");
	AST_DONE_PULSE: assert property (done |=> !done)
		else $error("done width");
	AST_WB_DONE: assert property (wb_valid |-> done)
		else $error("write-back time");
	AST_BUSY: assert property (go |=> !issue_ready)
		else $error("ready while busy");
	AST_HALT_BLOCK: assert property ((halt_mode || stop_mode) |->
		!issue_ready)
		else $error("ready while asleep");
	AST_SLVERR: assert property (pslverr == (psel && penable && !mapped))
		else $error("slave error");
endmodule : bcx_exec_chk
bind bcx_exec bcx_exec_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .pslverr, .issue_valid, .issue_ready, .issue_op,
	.issue_mode, .issue_addr16, .issue_fetch_extra, .done, .wb_valid, .pc,
	.program_status_word, .int_master_enable, .bank_choice_bits, .halt_mode, .stop_mode);

// ===== verification/bcx_exec_tb.sv
// Self-checking bench of the branch and CPU-control unit
`timescale 1ns/1ps
`include "bcx_cfg.svh"
module bcx_exec_tb;
	logic               pclk = 1'b0;
	logic               presetn = 1'b0;
	logic               psel = 1'b0;
	logic               penable = 1'b0;
	logic               pwrite = 1'b0;
	logic [11:0]        paddr = 12'h000;
	logic [31:0]        pwdata = 32'h00000000;
	logic               wake = 1'b0;
	logic [31:0]        prdata, r;
	logic               pready, pslverr, issue_valid, issue_ready, e;
	bcx_pkg::bcx_op_t   issue_op;
	bcx_pkg::bcx_mode_t issue_mode, wb_sel, lws;
	logic [15:0]        issue_addr16, pc;
	logic [15:0]        epc = 16'h0000;
	logic [7:0]         issue_offset, issue_fetch_extra, opnd_data, acc_data;
	logic [7:0]         x_data, b_data, c_data, wb_data, program_status_word, lwd;
	logic [2:0]         issue_bit;
	logic [1:0]         issue_bank, bank_choice_bits;
	logic [3:0]         issue_rd_waits, issue_wr_waits;
	logic               issue_fast_area, done, taken, wb_valid, lwb;
	logic               int_master_enable, halt_mode, stop_mode;
	int                 bad_count = 0;
	int                 n_compared = 0;
	int                 cyc = 0;
	always #10 pclk = ~pclk;
	bcx_exec u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .issue_valid, .issue_ready,
		.issue_op, .issue_mode, .issue_addr16, .issue_offset, .issue_bit,
		.issue_bank, .issue_fast_area, .issue_fetch_extra, .issue_rd_waits,
		.issue_wr_waits, .opnd_data, .acc_data, .x_data, .b_data, .c_data,
		.wake, .done, .taken, .pc, .wb_valid, .wb_sel, .wb_data, .program_status_word,
		.int_master_enable, .bank_choice_bits, .halt_mode, .stop_mode);
	bcx_fetch_model u_fetch (.pclk, .issue_ready, .issue_valid, .issue_op,
		.issue_mode, .issue_addr16, .issue_offset, .issue_bit, .issue_bank,
		.issue_fast_area, .issue_fetch_extra, .issue_rd_waits,
		.issue_wr_waits, .opnd_data, .acc_data, .x_data, .b_data, .c_data);
	task automatic chk(input string nm, input logic [31:0] x,
			input logic [31:0] g);
		n_compared++;
		if (g !== x) begin
			bad_count++;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, x, g);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a,
			input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wait_done(output int k);
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (done !== 1'b1 && k < 400);
		lwb = wb_valid;
		lwd = wb_data;
		lws = wb_sel;
	endtask : wait_done
	task automatic run(input bcx_pkg::bcx_op_t op,
			input bcx_pkg::bcx_mode_t md, input logic [7:0] off,
			input logic [2:0] b, input logic f, input logic [7:0] d,
			input int t, input logic tk, input logic [15:0] len,
			input logic [15:0] a = 16'h0000, input logic [7:0] ex = 8'h00,
			input logic [3:0] n = 4'h0, input logic [3:0] m = 4'h0);
		int k;
		logic [15:0] tgt;
		tgt = epc + len;
		if (tk && md == bcx_pkg::MD_ABS)
			tgt = a;
		else if (tk && md == bcx_pkg::MD_AX)
			tgt = {d, off};
		else if (tk)
			tgt = tgt + {{8{off[7]}}, off};
		u_fetch.send(op, md, a, off, b, f, ex, n, m, d);
		wait_done(k);
		chk("cycles", t + 1, k);
		chk("pc", tgt, pc);
		if (op <= bcx_pkg::OP_DEC_JNZ)
			chk("taken", tk, taken);
		epc = tgt;
	endtask : run
	task automatic t_regs;
		apb(1'b0, `BCX_ADDR_CTRL, 32'h00000000);
		chk("ctrl", 32'h00000000, r);
		apb(1'b1, `BCX_ADDR_PC, 32'h0000FFFF);
		apb(1'b0, `BCX_ADDR_PC, 32'h00000000);
		chk("pc ro", 32'h00000000, r);
		apb(1'b0, 12'h014, 32'h00000000);
		chk("unmapped", 33'h000000001, {r, e});
		$display("END t_regs");
	endtask : t_regs
	task automatic t_jumps;
		bcx_pkg::bcx_op_t ops [4];
		ops = '{bcx_pkg::OP_JUMP_IF_CARRY, bcx_pkg::OP_JUMP_IF_NO_CY,
			bcx_pkg::OP_JUMP_IF_ZERO, bcx_pkg::OP_JUMP_IF_NZ};
		run(bcx_pkg::OP_JUMP_ALWAYS, bcx_pkg::MD_ABS, 8'h00, 3'h0, 1'b1,
			8'h00, 12, 1'b1, 16'h0003, 16'h1234);
		run(bcx_pkg::OP_JUMP_ALWAYS, bcx_pkg::MD_REL, 8'hF0, 3'h0, 1'b1,
			8'h00, 12, 1'b1, 16'h0002);
		run(bcx_pkg::OP_JUMP_ALWAYS, bcx_pkg::MD_AX, 8'h56, 3'h0, 1'b1,
			8'h20, 16, 1'b1, 16'h0002);
		for (int i = 0; i < 4; i++) begin
			run(ops[i], bcx_pkg::MD_REL, 8'h06, 3'h0, 1'b1, 8'h00, 12, i[0],
				16'h0002);
		end
		$display("END t_jumps");
	endtask : t_jumps
	task automatic t_bits;
		run(bcx_pkg::OP_BIT_SET, bcx_pkg::MD_SHORT, 8'h10, 3'h3, 1'b0,
			8'h08, 18, 1'b1, 16'h0003);
		run(bcx_pkg::OP_BIT_SET, bcx_pkg::MD_SFR, 8'h10, 3'h2, 1'b1,
			8'h08, 22, 1'b0, 16'h0004);
		run(bcx_pkg::OP_BIT_CLEAR, bcx_pkg::MD_SHORT, 8'hF8, 3'h2, 1'b1,
			8'h08, 20, 1'b1, 16'h0004);
		run(bcx_pkg::OP_TEST_CLEAR, bcx_pkg::MD_SHORT, 8'h08, 3'h3, 1'b1,
			8'h08, 20, 1'b1, 16'h0004);
		chk("wb", 13'h1300, {lwb, lws, lwd});
		run(bcx_pkg::OP_BIT_SET, bcx_pkg::MD_IND, 8'h04, 3'h0, 1'b0,
			8'h01, 28, 1'b1, 16'h0003, 16'h0000, 8'h00, 4'h3);
		run(bcx_pkg::OP_TEST_CLEAR, bcx_pkg::MD_IND, 8'h04, 3'h0, 1'b0,
			8'h01, 30, 1'b1, 16'h0003, 16'h0000, 8'h00, 4'h1, 4'h2);
		chk("wb ind", 13'h1700, {lwb, lws, lwd});
		$display("END t_bits");
	endtask : t_bits
	task automatic t_psw;
		run(bcx_pkg::OP_INTS_ON, bcx_pkg::MD_NONE, 8'h00, 3'h0, 1'b1,
			8'h00, 12, 1'b0, 16'h0002);
		chk("ie on", 32'h00000001, int_master_enable);
		run(bcx_pkg::OP_BIT_SET, bcx_pkg::MD_PSW, 8'h0C, 3'h7, 1'b1,
			8'h00, 18, 1'b1, 16'h0003);
		run(bcx_pkg::OP_TEST_CLEAR, bcx_pkg::MD_PSW, 8'h0C, 3'h7, 1'b1,
			8'h00, 24, 1'b1, 16'h0004);
		chk("ie cleared", 32'h00000000, int_master_enable);
		run(bcx_pkg::OP_INTS_ON, bcx_pkg::MD_NONE, 8'h00, 3'h0, 1'b1,
			8'h00, 12, 1'b0, 16'h0002);
		run(bcx_pkg::OP_INTS_OFF, bcx_pkg::MD_NONE, 8'h00, 3'h0, 1'b1,
			8'h00, 12, 1'b0, 16'h0002);
		apb(1'b0, `BCX_ADDR_PSW, 32'h00000000);
		chk("ie off", 32'h00000000, r[7]);
		$display("END t_psw");
	endtask : t_psw
	task automatic t_dec;
		run(bcx_pkg::OP_DEC_JNZ, bcx_pkg::MD_REGB, 8'h20, 3'h0, 1'b1,
			8'h01, 12, 1'b0, 16'h0002);
		chk("dec b", 13'h1800, {lwb, lws, lwd});
		run(bcx_pkg::OP_DEC_JNZ, bcx_pkg::MD_SHORT, 8'h20, 3'h0, 1'b0,
			8'h05, 20, 1'b1, 16'h0003);
		chk("dec short", 13'h1304, {lwb, lws, lwd});
		$display("END t_dec");
	endtask : t_dec
	task automatic t_ctl;
		bcx_pkg::bcx_op_t op;
		int k;
		run(bcx_pkg::OP_NO_OPERATION, bcx_pkg::MD_NONE, 8'h00, 3'h0, 1'b1,
			8'h00, 9, 1'b0, 16'h0001, 16'h0000, 8'h05);
		apb(1'b1, `BCX_ADDR_CTRL, 32'h00000001);
		apb(1'b0, `BCX_ADDR_CTRL, 32'h00000000);
		chk("ctrl", 32'h00000001, r);
		// Divider phase is free-running, so only a window can be expected
		u_fetch.send(bcx_pkg::OP_NO_OPERATION, bcx_pkg::MD_NONE, 16'h0000,
			8'h00, 3'h0, 1'b1, 8'h00, 4'h0, 4'h0, 8'h00);
		wait_done(k);
		chk("slow nop", 32'h00000001, k >= 8 && k <= 9);
		epc = epc + 16'h0001;
		chk("pc", epc, pc);
		apb(1'b1, `BCX_ADDR_CTRL, 32'h00000000);
		run(bcx_pkg::OP_BANK_CHOOSE, bcx_pkg::MD_NONE, 8'h00, 3'h2, 1'b1,
			8'h00, 8, 1'b0, 16'h0002);
		chk("bank", 32'h00000002, bank_choice_bits);
		apb(1'b0, `BCX_ADDR_CYC, 32'h00000000);
		chk("cyc", 32'h00000008, r);
		for (int i = 0; i < 2; i++) begin
			op = i ? bcx_pkg::OP_STOP : bcx_pkg::OP_HALT;
			run(op, bcx_pkg::MD_NONE, 8'h00, 3'h0, 1'b1, 8'h00, 12, 1'b0,
				16'h0002);
			@(posedge pclk);
			chk("mode", 32'h00000001, i ? stop_mode : halt_mode);
			chk("refused", 32'h00000000, issue_ready);
			apb(1'b0, `BCX_ADDR_STAT, 32'h00000000);
			chk("stat", i ? 32'h00000008 : 32'h00000004, r);
			wake <= 1'b1;
			@(posedge pclk);
			wake <= 1'b0;
			@(posedge pclk);
			chk("woken", 32'h00000000, {halt_mode, stop_mode});
		end
		$display("END t_ctl");
	endtask : t_ctl
	task automatic stop_test;
		$display("compared %0d mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : stop_test
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 6000) begin
			bad_count++;
			$display("CHECK FAILED run time expected end seen none");
			stop_test;
		end
	end
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_jumps;
		t_bits;
		t_psw;
		t_dec;
		t_ctl;
		stop_test;
	end
endmodule : bcx_exec_tb

// ===== verification/bcx_fetch_model.sv
// Fetch-side model that hands one decoded instruction at a time to the unit
`timescale 1ns/1ps
module bcx_fetch_model (
	input  wire logic          pclk,
	input  wire logic          issue_ready,
	output logic               issue_valid,
	output bcx_pkg::bcx_op_t   issue_op,
	output bcx_pkg::bcx_mode_t issue_mode,
	output logic [15:0]        issue_addr16,
	output logic [7:0]         issue_offset,
	output logic [2:0]         issue_bit,
	output logic [1:0]         issue_bank,
	output logic               issue_fast_area,
	output logic [7:0]         issue_fetch_extra,
	output logic [3:0]         issue_rd_waits,
	output logic [3:0]         issue_wr_waits,
	output logic [7:0]         opnd_data,
	output logic [7:0]         acc_data,
	output logic [7:0]         x_data,
	output logic [7:0]         b_data,
	output logic [7:0]         c_data
);
	initial begin
		issue_valid = 1'b0;
		issue_op = bcx_pkg::OP_NO_OPERATION;
		issue_mode = bcx_pkg::MD_NONE;
		{issue_addr16, issue_offset, issue_bit, issue_bank} = '0;
		{issue_fast_area, issue_fetch_extra, issue_rd_waits} = '0;
		{issue_wr_waits, opnd_data, acc_data, x_data, b_data, c_data} = '0;
	end
	task automatic send(input bcx_pkg::bcx_op_t op,
			input bcx_pkg::bcx_mode_t md, input logic [15:0] a,
			input logic [7:0] off, input logic [2:0] b, input logic f,
			input logic [7:0] ex, input logic [3:0] n, input logic [3:0] m,
			input logic [7:0] d);
		int k;
		@(posedge pclk);
		issue_valid <= 1'b1;
		issue_op <= op;
		issue_mode <= md;
		issue_addr16 <= a;
		issue_offset <= off;
		issue_bit <= b;
		issue_bank <= b[1:0];
		issue_fast_area <= f;
		issue_fetch_extra <= ex;
		issue_rd_waits <= n;
		issue_wr_waits <= m;
		{opnd_data, acc_data, b_data, c_data} <= {4{d}};
		x_data <= off;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (issue_ready !== 1'b1 && k < 100);
		issue_valid <= 1'b0;
		// Operands count only at acceptance, so stale data is shown inverted
		{opnd_data, acc_data, b_data, c_data} <= ~{4{d}};
		x_data <= ~off;
	endtask : send
endmodule : bcx_fetch_model
